// file: core/drpds_pkg.sv
// drpds_pkg: constants, carrier struct and state codes of the refresh and power-down sequencer
// assumes a single 25 MHz core clock; every cycle count converted from ns below is derived from it
package drpds_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 40;
  localparam int REFRESH_MAX_NS     = 30000;
  // longest allowed gap rounds down to whole cycles
  localparam int REFRESH_MAX_CYC    = REFRESH_MAX_NS / CLK_PERIOD_NS;
  // slack for one access cycle plus the refresh cycle itself
  localparam int REFRESH_MARGIN_CYC = 16;
  localparam int REFRESH_REQ_CYC    = REFRESH_MAX_CYC - REFRESH_MARGIN_CYC;
  localparam int SAVE_INTERVAL_NS   = 2000000;
  localparam int SAVE_INTERVAL_CYC  = SAVE_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int SUP_PULSE_CYC      = 4;

  // ---------------------------------------------------------------
  // array organisation
  // ---------------------------------------------------------------
  localparam int ELEM_WORDS  = 4096;
  localparam int HALF_W      = 6;
  localparam int SEG_CNT     = 16;
  localparam int SEG_W       = 4;
  localparam int CAS_GRP     = 4;
  localparam int WORD_W      = 18;
  localparam int MADDR_W     = 16;
  localparam int BURST_LEN   = 64;
  localparam int ROW_LSB     = 0;
  localparam int COL_LSB     = 6;
  localparam int SEG_LSB     = 12;
  localparam logic [HALF_W-1:0] REF_ADDR_RST  = 6'h00;
  localparam logic [HALF_W-1:0] REF_ADDR_LAST = 6'h3f;
  localparam logic [2:0]        SUP_CNT_LOAD  = 3'h3;

  // strobes, chip select, write and address pins of the array
  typedef struct packed {
    logic [SEG_CNT-1:0] row_strobe_n;
    logic [CAS_GRP-1:0] col_strobe_n;
    logic               chip_sel_n;
    logic               write_n;
    logic [HALF_W-1:0]  addr;
  } drpds_ram_ctl_t;

  localparam drpds_ram_ctl_t RAM_CTL_IDLE = '{row_strobe_n: 16'hffff, col_strobe_n: 4'hf,
                                              chip_sel_n: 1'b1, write_n: 1'b1, addr: 6'h00};

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_RSET  = 3'b001,
    S_ROW   = 3'b010,
    S_CSET  = 3'b011,
    S_COL   = 3'b100,
    S_END   = 3'b101
  } drpds_state_t;

endpackage : drpds_pkg

// file: core/drpds_timer.sv
// drpds_timer: reloadable down-counter giving a one-cycle done pulse
// assumes start_i is a one-cycle pulse; done comes CYCLES+1 edges after start
`timescale 1ns/1ps
module drpds_timer #(
  parameter int W      = 16,
  parameter int CYCLES = 1
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  logic [W-1:0] cnt_reg;
  logic         done_reg;

  // ---------------------------------------------------------------
  // count down
  // ---------------------------------------------------------------
  // a new start reloads even when running, so the interval restarts cleanly
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (start_i) begin
      cnt_reg <= W'(CYCLES);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  // done on the last count only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (cnt_reg == W'(1)) && !start_i;
    end
  end

  assign busy_o = (cnt_reg != '0);
  assign done_o = done_reg;

endmodule : drpds_timer

// file: core/drpds_sequencer.sv
// drpds_sequencer: strobes and address multiplexing for a 4K x 1 dynamic RAM array,
// periodic refresh, and power-down / data-save burst refresh sequencing
// assumes arbitration is done outside; one request is held until its acknowledge
//
// Function
// - each element holds one bit of 4096 words
// - twelve address bits, row six then column six
// - row bits stable before row strobe falls
// - column bits, column strobe, chip select low
// - refresh keeps chip select high, same address
// - refresh column strobe only disables data output
// - chip select high blocks data latches
// - system reset low pulls internal reset, pulse
// - supply pulse presets burst flop, clears counter
// - preset drops overflow latch, releases internal reset
// - burst starts when pulse ends, reset, status high
// - 64 refresh cycles, overflow fires voltage one-shot
// - one-shot drops status, raises supply disable
// - data-save repeats burst every two milliseconds
// - refresh asserts all sixteen row strobes together
// - refresh at least every 30 microseconds
`timescale 1ns/1ps
module drpds_sequencer
  import drpds_pkg::*;
#(
  parameter int SAVE_CYC = SAVE_INTERVAL_CYC
) (
  input  wire logic                core_clk_i,
  input  wire logic                nrst_i,
  input  wire logic                power_fail_alarm_n_i,
  input  wire logic                system_reset_n_i,
  input  wire logic                data_save_i,
  input  wire logic                mem_req_i,
  input  wire logic                mem_we_i,
  input  wire logic [MADDR_W-1:0]  mem_addr_i,
  input  wire logic [WORD_W-1:0]   mem_wdata_i,
  input  wire logic [WORD_W-1:0]   ram_dout_i,
  output logic                     mem_ack_o,
  output logic [WORD_W-1:0]        mem_rdata_o,
  output drpds_ram_ctl_t           ram_ctl_o,
  output logic [WORD_W-1:0]        ram_din_o,
  output logic                     internal_reset_n_o,
  output logic                     supply_up_pulse_n_o,
  output logic                     counter_overflow_latched_n_o,
  output logic                     refresh_counter_overflow_o,
  output logic                     burst_enable_o,
  output logic                     supply_on_status_o,
  output logic                     supply_disable_o
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_s1_reg;
  logic rst_n_reg;

  // asynchronous assert, two-flop release
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  drpds_state_t      state_reg;
  drpds_state_t      state_next;
  drpds_ram_ctl_t    ctl_reg;
  drpds_ram_ctl_t    ctl_next;
  logic              is_ref_reg;
  logic [MADDR_W-1:0] acc_addr_reg;
  logic [WORD_W-1:0] din_reg;
  logic [WORD_W-1:0] rdata_reg;
  logic              ack_reg;
  logic [HALF_W-1:0] ref_addr_reg;
  logic              overflow_reg;
  logic              ref_pending_reg;
  logic              sys_rst_prev_reg;
  logic              internal_reset_n_prev_reg;
  logic              internal_reset_n_reg;
  logic [2:0]        sup_cnt_reg;
  logic              sup_n_reg;
  logic              burst_ff_reg;
  logic              ovl_n_reg;
  logic              burst_en_reg;
  logic              sts_reg;
  logic              sdis_reg;
  logic              take_ref;
  logic              take_acc;
  logic              ref_end;
  logic              vc_fire;
  logic              ref_tmr_done;
  logic              save_tmr_done;

  assign ref_end = (state_reg == S_END) && is_ref_reg;
  // overflow at the end of a burst fires the voltage control one-shot
  assign vc_fire = overflow_reg && burst_en_reg;

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  // periodic refresh interval, restarted by every completed refresh
  drpds_timer #(.W(10), .CYCLES(REFRESH_REQ_CYC)) u_ref_tmr (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n_reg),
    .start_i (ref_end),
    .busy_o  (),
    .done_o  (ref_tmr_done)
  );

  // data-save interval between bursts while the supplies are off
  drpds_timer #(.W(20), .CYCLES(SAVE_CYC)) u_save_tmr (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n_reg),
    .start_i (vc_fire && data_save_i),
    .busy_o  (),
    .done_o  (save_tmr_done)
  );

  // ---------------------------------------------------------------
  // cycle sequencer
  // ---------------------------------------------------------------
  // pending refresh wins over a waiting access; burst refreshes run back to back
  assign take_ref = ref_pending_reg || (burst_en_reg && !overflow_reg);
  assign take_acc = !take_ref && mem_req_i && !burst_ff_reg;

  // strobes are computed for the next state so every pin comes from a flop
  always_comb begin
    state_next = state_reg;
    ctl_next   = ctl_reg;
    case (state_reg)
      S_IDLE: begin
        if (take_ref) begin
          state_next    = S_RSET;
          ctl_next.addr = ref_addr_reg;
        end else if (take_acc) begin
          state_next       = S_RSET;
          ctl_next.addr    = mem_addr_i[ROW_LSB +: HALF_W];
          ctl_next.write_n = !mem_we_i;
        end
      end
      S_RSET: begin
        state_next = S_ROW;
        // address has stood a full cycle when the row strobe falls
        if (is_ref_reg) begin
          ctl_next.row_strobe_n = '0;
        end else begin
          ctl_next.row_strobe_n = ~(SEG_CNT'(1) << acc_addr_reg[SEG_LSB +: SEG_W]);
        end
      end
      S_ROW: begin
        state_next = S_CSET;
        // refresh repeats the row address as column; chip select stays high
        // refresh keeps its taken address even if the supply-up pulse clears the counter mid-cycle
        ctl_next.addr       = is_ref_reg ? ctl_reg.addr : acc_addr_reg[COL_LSB +: HALF_W];
        ctl_next.chip_sel_n = is_ref_reg;
      end
      S_CSET: begin
        state_next            = S_COL;
        // in refresh the column strobe only parks the data output
        ctl_next.col_strobe_n = '0;
      end
      S_COL: begin
        state_next = S_END;
        ctl_next   = RAM_CTL_IDLE;
      end
      S_END: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
        ctl_next   = RAM_CTL_IDLE;
      end
    endcase
  end

  // state and pin registers
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= S_IDLE;
      ctl_reg   <= RAM_CTL_IDLE;
    end else begin
      state_reg <= state_next;
      ctl_reg   <= ctl_next;
    end
  end

  // capture of the request; one element per bit keeps the whole word in one place
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      is_ref_reg   <= 1'b0;
      acc_addr_reg <= '0;
      din_reg      <= '0;
    end else if (state_reg == S_IDLE) begin
      is_ref_reg <= take_ref;
      if (take_acc) begin
        acc_addr_reg <= mem_addr_i;
        din_reg      <= mem_wdata_i;
      end
    end
  end

  // read data taken at the end of the column phase, acknowledge for one cycle
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg <= '0;
      ack_reg   <= 1'b0;
    end else begin
      ack_reg <= (state_reg == S_COL) && !is_ref_reg;
      if ((state_reg == S_COL) && !is_ref_reg && ctl_reg.write_n) begin
        rdata_reg <= ram_dout_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // refresh counter and request
  // ---------------------------------------------------------------
  // the supply-up pulse clears the counter and beats an advance
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ref_addr_reg <= REF_ADDR_RST;
      overflow_reg <= 1'b0;
    end else if (!sup_n_reg) begin
      ref_addr_reg <= REF_ADDR_RST;
      overflow_reg <= 1'b0;
    end else begin
      overflow_reg <= ref_end && (ref_addr_reg == REF_ADDR_LAST);
      if (ref_end) begin
        ref_addr_reg <= ref_addr_reg + HALF_W'(1);
      end
    end
  end

  // timer expiry sets pending; set wins when it meets the clearing refresh
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ref_pending_reg <= 1'b1;
    end else if (ref_tmr_done) begin
      ref_pending_reg <= 1'b1;
    end else if ((state_reg == S_IDLE) && take_ref) begin
      ref_pending_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // power-down sequencing
  // ---------------------------------------------------------------
  // internal reset falls with system reset and is released by the preset burst flop
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sys_rst_prev_reg <= 1'b1;
      internal_reset_n_prev_reg    <= 1'b1;
      internal_reset_n_reg         <= 1'b1;
    end else begin
      sys_rst_prev_reg <= system_reset_n_i;
      internal_reset_n_prev_reg    <= internal_reset_n_reg;
      if (sys_rst_prev_reg && !system_reset_n_i) begin
        internal_reset_n_reg <= 1'b0;
      end else if (burst_ff_reg) begin
        internal_reset_n_reg <= 1'b1;
      end
    end
  end

  // one-shot on the falling internal reset gives a short low supply-up pulse
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sup_cnt_reg <= '0;
      sup_n_reg   <= 1'b1;
    end else if (internal_reset_n_prev_reg && !internal_reset_n_reg) begin
      sup_cnt_reg <= SUP_CNT_LOAD;
      sup_n_reg   <= 1'b0;
    end else if (sup_cnt_reg != '0) begin
      sup_cnt_reg <= sup_cnt_reg - 3'h1;
    end else begin
      sup_n_reg <= 1'b1;
    end
  end

  // burst flop: preset by the pulse, cleared only once power is back
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      burst_ff_reg <= 1'b0;
      ovl_n_reg    <= 1'b1;
    end else if (!sup_n_reg) begin
      burst_ff_reg <= 1'b1;
      ovl_n_reg    <= 1'b0;
    end else if (system_reset_n_i && power_fail_alarm_n_i && sys_rst_prev_reg) begin
      burst_ff_reg <= 1'b0;
      ovl_n_reg    <= 1'b1;
    end
  end

  // burst enable needs the pulse over, internal reset high and supplies on
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      burst_en_reg <= 1'b0;
    end else begin
      burst_en_reg <= burst_ff_reg && sup_n_reg && internal_reset_n_reg && sts_reg && !vc_fire;
    end
  end

  // voltage control: off after each burst, back on after the save interval
  // limitation: without data-save the supplies stay off until power returns
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sts_reg  <= 1'b1;
      sdis_reg <= 1'b0;
    end else if (vc_fire) begin
      sts_reg  <= 1'b0;
      sdis_reg <= 1'b1;
    end else if (save_tmr_done || !burst_ff_reg) begin
      sts_reg  <= 1'b1;
      sdis_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign ram_ctl_o                    = ctl_reg;
  assign ram_din_o                    = din_reg;
  assign mem_ack_o                    = ack_reg;
  assign mem_rdata_o                  = rdata_reg;
  assign internal_reset_n_o           = internal_reset_n_reg;
  assign supply_up_pulse_n_o          = sup_n_reg;
  assign counter_overflow_latched_n_o = ovl_n_reg;
  assign refresh_counter_overflow_o   = overflow_reg;
  assign burst_enable_o               = burst_en_reg;
  assign supply_on_status_o           = sts_reg;
  assign supply_disable_o             = sdis_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [9:0] gap_reg;

  // cycles since the last completed refresh
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      gap_reg <= '0;
    end else if (ref_end) begin
      gap_reg <= '0;
    end else if (gap_reg != 10'h3ff) begin
      gap_reg <= gap_reg + 10'h1;
    end
  end

  property p_row_addr_setup;
    @(posedge core_clk_i) disable iff (!rst_n_reg)
      (ctl_reg.row_strobe_n != 16'hffff) && $past(ctl_reg.row_strobe_n == 16'hffff)
      |-> ctl_reg.addr == $past(ctl_reg.addr);
  endproperty
  a_row_addr_setup: assert property (p_row_addr_setup) else $error("row address moved as row strobe fell");

  property p_acc_col;
    @(posedge core_clk_i) disable iff (!rst_n_reg)
      (state_reg == S_CSET) && !is_ref_reg |=> !ctl_reg.chip_sel_n && (ctl_reg.col_strobe_n == 4'h0)
      && (ctl_reg.addr == acc_addr_reg[COL_LSB +: HALF_W]);
  endproperty
  a_acc_col: assert property (p_acc_col) else $error("access column phase wrong");

  property p_ref_cs_high;
    @(posedge core_clk_i) disable iff (!rst_n_reg)
      is_ref_reg && (state_reg inside {S_ROW, S_CSET, S_COL})
      |-> ctl_reg.chip_sel_n && (ctl_reg.addr == $past(ctl_reg.addr));
  endproperty
  a_ref_cs_high: assert property (p_ref_cs_high) else $error("refresh cycle lost chip select or address");

  property p_ref_all_rows;
    @(posedge core_clk_i) disable iff (!rst_n_reg)
      is_ref_reg && (state_reg == S_RSET) |=> (ctl_reg.row_strobe_n == 16'h0000) [*3];
  endproperty
  a_ref_all_rows: assert property (p_ref_all_rows) else $error("refresh did not strobe all rows");

  property p_refresh_gap;
    @(posedge core_clk_i) disable iff (!rst_n_reg)
      !burst_ff_reg |-> gap_reg < 10'(REFRESH_MAX_CYC);
  endproperty
  a_refresh_gap: assert property (p_refresh_gap) else $error("refresh interval exceeded");

  property p_counter_adv;
    @(posedge core_clk_i) disable iff (!rst_n_reg)
      ref_end && sup_n_reg |=> ref_addr_reg == $past(ref_addr_reg) + 6'h01;
  endproperty
  a_counter_adv: assert property (p_counter_adv) else $error("refresh counter did not advance");

  property p_internal_reset_n_fall;
    @(posedge core_clk_i) disable iff (!rst_n_reg)
      $fell(system_reset_n_i) |=> !internal_reset_n_reg ##2 !sup_n_reg;
  endproperty
  a_internal_reset_n_fall: assert property (p_internal_reset_n_fall) else $error("reset did not start supply-up pulse");

  property p_sup_preset;
    @(posedge core_clk_i) disable iff (!rst_n_reg)
      !sup_n_reg |=> burst_ff_reg && !ovl_n_reg && (ref_addr_reg == 6'h00) ##1 internal_reset_n_reg;
  endproperty
  a_sup_preset: assert property (p_sup_preset) else $error("supply-up pulse did not preset");

  property p_burst_start;
    @(posedge core_clk_i) disable iff (!rst_n_reg)
      $rose(sup_n_reg) && burst_ff_reg && internal_reset_n_reg && sts_reg |=> burst_en_reg;
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst did not start");

  property p_vc_off;
    @(posedge core_clk_i) disable iff (!rst_n_reg)
      vc_fire |=> !sts_reg && sdis_reg && !burst_en_reg;
  endproperty
  a_vc_off: assert property (p_vc_off) else $error("supplies not switched off after burst");

  property p_save_on;
    @(posedge core_clk_i) disable iff (!rst_n_reg)
      save_tmr_done && !vc_fire |=> sts_reg && !sdis_reg;
  endproperty
  a_save_on: assert property (p_save_on) else $error("data-save interval did not restore status");

endmodule : drpds_sequencer

// file: test/drpds_dram_model.sv
// dram array model: sixteen 4K segments of 18-bit words behind one strobe bus
// assumes strobes move only on rising core clock edges
`timescale 1ns/1ps
module drpds_dram_model
  import drpds_pkg::*;
(
  input  wire logic              clk_i,
  input  wire drpds_ram_ctl_t    ctl_i,
  input  wire logic [WORD_W-1:0] din_i,
  output logic      [WORD_W-1:0] dout_o
);
  logic [WORD_W-1:0] mem [SEG_CNT*ELEM_WORDS];
  logic [HALF_W-1:0] row_q;
  logic [SEG_W-1:0]  seg_q;
  logic              ras_q = 1'b1;
  logic              cas_q = 1'b1;

  // ---------------
  // cell access
  // ---------------
  // sampled mid-cycle so read data is settled before the next rising edge
  initial dout_o = '0;
  always @(negedge clk_i) begin
    if (ras_q && !(&ctl_i.row_strobe_n)) begin
      row_q <= ctl_i.addr;
      for (int s = 0; s < SEG_CNT; s++)
        if (!ctl_i.row_strobe_n[s]) seg_q <= s[SEG_W-1:0];
    end
    if (cas_q && !(&ctl_i.col_strobe_n) && !ctl_i.chip_sel_n) begin
      if (!ctl_i.write_n)
        mem[{seg_q, row_q, ctl_i.addr}] <= din_i;
      else
        dout_o <= mem[{seg_q, row_q, ctl_i.addr}];
    end else if ((&ctl_i.col_strobe_n) || ctl_i.chip_sel_n) begin
      dout_o <= ~dout_o;  // disabled output toggles every cycle instead of holding stale data
    end
    ras_q <= &ctl_i.row_strobe_n;
    cas_q <= &ctl_i.col_strobe_n;
  end
endmodule : drpds_dram_model

// file: test/drpds_sequencer_tb_top.sv
// testbench of the refresh and power-down sequencer against a dram array model
// assumes a shortened data-save interval and one request at a time
`timescale 1ns/1ps
module drpds_sequencer_tb_top
  import drpds_pkg::*;
;
  localparam int SAVE_SIM = 200;
  logic               core_clk_i, nrst_i, power_fail_alarm_n_i, system_reset_n_i, data_save_i;
  logic               mem_req_i, mem_we_i, mem_ack_o, ref_on;
  logic [MADDR_W-1:0] mem_addr_i;
  logic [WORD_W-1:0]  mem_wdata_i, ram_dout_i, mem_rdata_o, ram_din_o;
  drpds_ram_ctl_t     ram_ctl_o;
  logic               internal_reset_n_o, supply_up_pulse_n_o, counter_overflow_latched_n_o;
  logic               refresh_counter_overflow_o, burst_enable_o, supply_on_status_o, supply_disable_o;
  logic [7:0]         flags;
  logic [HALF_W-1:0]  ref_exp = REF_ADDR_RST;
  logic [HALF_W-1:0]  ref_cur = REF_ADDR_RST;
  int                 num_errors = 0, compares = 0, ref_cnt = 0, gap = 0, acks = 0;

  drpds_sequencer #(.SAVE_CYC(SAVE_SIM)) drpds_sequencer_inst (
    .core_clk_i, .nrst_i, .power_fail_alarm_n_i, .system_reset_n_i, .data_save_i, .mem_req_i,
    .mem_we_i, .mem_addr_i, .mem_wdata_i, .ram_dout_i, .mem_ack_o, .mem_rdata_o, .ram_ctl_o,
    .ram_din_o, .internal_reset_n_o, .supply_up_pulse_n_o, .counter_overflow_latched_n_o,
    .refresh_counter_overflow_o, .burst_enable_o, .supply_on_status_o, .supply_disable_o);
  drpds_dram_model drpds_dram_model_inst (
    .clk_i(core_clk_i), .ctl_i(ram_ctl_o), .din_i(ram_din_o), .dout_o(ram_dout_i));

  assign flags = {mem_ack_o, supply_disable_o, supply_on_status_o, burst_enable_o,
                  refresh_counter_overflow_o, counter_overflow_latched_n_o, supply_up_pulse_n_o,
                  internal_reset_n_o};

  // ---------------
  // helpers
  // ---------------
  task automatic check_val(input string what, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  // bounded wait on one status flag, n returns the edges it took
  task automatic wait_flag(input int k, input logic lvl, input int lim, input string what, output int n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (flags[k] !== lvl && n < lim);
    check_val(what, {17'h0, lvl}, {17'h0, flags[k]});
  endtask : wait_flag

  // request held to the edge that samples ack, then dropped; one edge passes before the next call
  task automatic access(input logic we, input logic [MADDR_W-1:0] a, input logic [WORD_W-1:0] d,
                        output logic [WORD_W-1:0] q);
    int n;
    n = 0;
    mem_we_i    <= we;
    mem_addr_i  <= a;
    mem_wdata_i <= d;
    mem_req_i   <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while ($countones(ram_ctl_o.row_strobe_n) != SEG_CNT - 1 && n < 40);
    check_val("row_strobe", {2'h0, ~(16'h1 << a[SEG_LSB+:SEG_W])}, {2'h0, ram_ctl_o.row_strobe_n});
    check_val("row_addr", {12'h0, a[ROW_LSB+:HALF_W]}, {12'h0, ram_ctl_o.addr});
    do begin
      @(posedge core_clk_i);
      n++;
    end while (mem_ack_o !== 1'b1 && n < 40);
    check_val("ack", 18'h1, {17'h0, mem_ack_o});
    q = mem_rdata_o;
    mem_req_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : access

  // refresh watcher: all row strobes, chip select idle, counter address held and advancing
  always @(posedge core_clk_i) begin
    gap = (!system_reset_n_i || supply_disable_o) ? 0 : gap + 1;
    acks += mem_ack_o;
    if (!supply_up_pulse_n_o)
      ref_exp = REF_ADDR_RST;
    if (nrst_i && !(|ram_ctl_o.row_strobe_n)) begin
      if (!ref_on) begin
        check_val("refresh_gap", 18'h1, {17'h0, gap <= REFRESH_MAX_CYC});
        check_val("refresh_addr", {12'h0, ref_exp}, {12'h0, ram_ctl_o.addr});
        ref_cur = ram_ctl_o.addr;
        ref_exp = ref_exp + 1'b1;
        ref_cnt++;
        gap = 0;
      end
      check_val("refresh_hold", {12'h0, ref_cur}, {12'h0, ram_ctl_o.addr});
      check_val("refresh_cs", 18'h1, {17'h0, ram_ctl_o.chip_sel_n});
    end
    if (!(&ram_ctl_o.col_strobe_n) && (|ram_ctl_o.row_strobe_n))
      check_val("access_cs", 18'h0, {17'h0, ram_ctl_o.chip_sel_n});
    ref_on = !(|ram_ctl_o.row_strobe_n);
  end

  // ---------------
  // scenarios
  // ---------------
  task automatic t_access();
    logic [MADDR_W-1:0] a [4] = '{16'h0000, 16'h7fc1, 16'hffff, 16'h8040};
    logic [WORD_W-1:0]  q;
    for (int i = 0; i < 4; i++)
      access(1'b1, a[i], {a[i][1:0], ~a[i]}, q);
    repeat (1600) @(posedge core_clk_i);  // spans two refresh periods
    for (int i = 0; i < 4; i++) begin
      access(1'b0, a[i], 18'h0, q);
      check_val("read_word", {a[i][1:0], ~a[i]}, q);
    end
  endtask : t_access

  task automatic burst();
    int n, c;
    c = ref_cnt;
    wait_flag(3, 1'b1, 400, "overflow", n);
    check_val("burst_len", 18'(BURST_LEN), 18'(ref_cnt - c));
    wait_flag(5, 1'b0, 2, "status_off", n);
    check_val("supply_off", 18'h1, {17'h0, supply_disable_o});
    check_val("burst_end", 18'h0, {17'h0, burst_enable_o});
  endtask : burst

  task automatic t_power_down();
    int n;
    data_save_i          <= 1'b1;
    power_fail_alarm_n_i <= 1'b0;
    repeat (25) @(posedge core_clk_i);  // alarm-to-reset delay shortened
    system_reset_n_i     <= 1'b0;
    wait_flag(0, 1'b0, 3, "int_reset_low", n);
    wait_flag(1, 1'b0, 3, "sup_pulse_low", n);
    wait_flag(2, 1'b0, 3, "ovl_latched_low", n);
    wait_flag(0, 1'b1, 3, "int_reset_high", n);
    wait_flag(4, 1'b1, 8, "burst_on", n);
    check_val("sup_pulse_end", 18'h1, {17'h0, supply_up_pulse_n_o});
    burst();
  endtask : t_power_down

  task automatic t_data_save();
    int n, k;
    k = acks;
    // a request while powered down must be ignored
    mem_req_i <= 1'b1;
    wait_flag(5, 1'b1, SAVE_SIM + 8, "status_back", n);
    mem_req_i <= 1'b0;
    check_val("refused_ack", 18'(k), 18'(acks));
    check_val("save_gap", 18'(SAVE_SIM + 1), 18'(n));
    check_val("supply_on", 18'h0, {17'h0, supply_disable_o});
    burst();
  endtask : t_data_save

  task automatic t_restore();
    int n;
    logic [WORD_W-1:0] q;
    data_save_i          <= 1'b0;
    power_fail_alarm_n_i <= 1'b1;
    system_reset_n_i     <= 1'b1;
    wait_flag(5, 1'b1, 20, "power_back", n);
    check_val("supply_back", 18'h0, {17'h0, supply_disable_o});
    access(1'b0, 16'hffff, 18'h0, q);
    check_val("saved_word", {2'h3, 16'h0000}, q);
  endtask : t_restore

  task automatic print_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // ---------------
  // run control
  // ---------------
  // clock at 25 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  // main sequence, power stays up until the power-down scenario
  initial begin
    nrst_i = 1'b0;
    power_fail_alarm_n_i = 1'b1;
    system_reset_n_i = 1'b1;
    data_save_i = 1'b0;
    mem_req_i = 1'b0;
    mem_we_i = 1'b0;
    mem_addr_i = '0;
    mem_wdata_i = '0;
    repeat (3) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    t_access();
    t_power_down();
    t_data_save();
    t_restore();
    print_verdict();
  end

  // watchdog, nearly four times the expected run
  initial begin
    repeat (10000) @(posedge core_clk_i);
    num_errors++;
    print_verdict();
  end
endmodule : drpds_sequencer_tb_top
